// *** design/cop_pkg.sv ***
// Package of constants and carrier types for the clock output stop and power-down control.
package cop_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int N_SE   = 6;
  localparam int N_DIFF = 2;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL    = 3'h0;
  localparam logic [ADDR_W-1:0] REG_SE_EN   = 3'h1;
  localparam logic [ADDR_W-1:0] REG_DIFF    = 3'h2;
  localparam logic [ADDR_W-1:0] REG_SE_STOP = 3'h3;
  localparam logic [ADDR_W-1:0] REG_FREE    = 3'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 3'h5;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_KEEP_BIT = 0;
  localparam int CTRL_MGMT_BIT = 3;
  localparam int DIFF_EN_LSB   = 0;
  localparam int DIFF_STOP_LSB = 2;
  localparam int DIFF_PD_LSB   = 4;
  localparam int FREE_FIRST_SE = 4;
  localparam int STAT_PCI_BIT  = 4;
  localparam int STAT_CPU_BIT  = 5;
  localparam int SECOND_CPU_PAIR_IDX      = 1;

  // ---------------------------------------------------------------------------
  // Timing: half periods of the output phases and the PCI resume window, in core clock cycles
  // ---------------------------------------------------------------------------
  localparam logic [3:0] PCI_HALF_CYC       = 4'h2;
  localparam logic [3:0] CPU_HALF_CYC       = 4'h1;
  localparam int         PCI_RESUME_PERIODS = 2;
  localparam int         PCI_RESUME_CYC     = PCI_RESUME_PERIODS * 2 * int'(PCI_HALF_CYC);

  // ---------------------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_LATCH = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_PDOWN = 4'b0100,
    ST_PART  = 4'b1000
  } cop_state_e;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cop_regbus_s;

  typedef struct packed {
    logic [N_SE-1:0] clk;
    logic [N_SE-1:0] oe_n;
  } cop_se_s;

  typedef struct packed {
    logic [N_DIFF-1:0] t;
    logic [N_DIFF-1:0] c;
    logic [N_DIFF-1:0] t_oe_n;
  } cop_diff_s;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] se_en;
    logic [DATA_W-1:0] diff;
    logic [DATA_W-1:0] se_stop;
    logic [DATA_W-1:0] free;
  } cop_cfg_s;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam cop_cfg_s CFG_DEFAULT = '{
    ctrl:    8'h00,
    se_en:   8'h3f,
    diff:    8'h0f,
    se_stop: 8'h3f,
    free:    8'h00
  };

endpackage

// *** design/cop_tick_div.sv ***
// Divider that pulses one cycle at every half period of an output phase.
`timescale 1ns/1ps
module cop_tick_div #(
  parameter logic [3:0] HALF = 4'h1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Half-period pulse
  output logic      tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } cop_div_s;

  cop_div_s s_reg;
  cop_div_s s_next;

  // Count to the half period and pulse once when it wraps.
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == HALF - 4'h1) begin
      s_next.cnt  = 4'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 4'h1;
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule

// *** design/cop_sync2.sv ***
// Two-stage synchroniser that advances only on an enable pulse.
`timescale 1ns/1ps
module cop_sync2 #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Sampling enable and data
  input  wire logic en,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } cop_sync_s;

  cop_sync_s s_reg;
  cop_sync_s s_next;

  // The first stage is read only by the second stage.
  always_comb begin
    s_next = s_reg;
    if (en) begin
      s_next.s1 = d;
      s_next.s2 = s_reg.s1;
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg <= '{s1: INIT, s2: INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule

// *** design/cop_ctrl.sv ***
// Output stop, disable and power-state gating for a multi-output clock generator.
// Notes on behaviour
// R1 - After the PCI halt input rises, stopped 33 MHz outputs restart cleanly within two periods.
// R2 - PCI halt holds stoppable single-ended outputs low; either halt parks stoppable pairs high.
// R3 - Outputs configured as non-stoppable keep running under either halt.
// R4 - A disabled single-ended output is low; a disabled pair is low or released to a pull-down.
// R5 - Low power drives outputs low (or high-Z by strap); CPU pair one runs in partial power.
// R6 - With keep-config and management mode clear, power-down performs a full reset and returns to latched-open.
// R7 - With keep-config set, the configuration survives power-down.
// R8 - With management mode set, keep-config is ignored and power-down never resets.
// R9 - The chipset drives the PCI halt input low to stop the 33 MHz outputs.
// R10 - Free-running 33 MHz outputs ignore PCI halt while their free-running bit is set.
// R11 - CPU halt parks stoppable pairs within two to six CPU periods after two CPU-edge samples.
// R12 - The asynchronous power-down input is synchronised before it acts.
// R13 - Stop and resume gating happens only at phase boundaries, so no pulse is cut or stretched.
`timescale 1ns/1ps
module cop_ctrl (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset_n,
  // Register port
  input  wire cop_pkg::cop_regbus_s            bus_req,
  output logic [cop_pkg::DATA_W-1:0]           bus_rdata,
  // Chipset controls
  input  wire logic                            pci_clock_halt_n,
  input  wire logic                            cpu_clock_halt_n,
  input  wire logic                            power_down_n_input,
  input  wire logic                            partial_power_state,
  // Output straps
  input  wire logic [cop_pkg::N_SE-1:0]        se_strap,
  // Gated outputs
  output cop_pkg::cop_se_s                     se_out,
  output cop_pkg::cop_diff_s                   diff_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    cop_pkg::cop_state_e             st;
    cop_pkg::cop_cfg_s               cfg;
    logic                            pci_ph;
    logic                            cpu_ph;
    logic [cop_pkg::N_SE-1:0]        se_run;
    logic [cop_pkg::N_DIFF-1:0]      diff_run;
    logic [cop_pkg::N_DIFF-1:0]      diff_on;
    logic [cop_pkg::N_SE-1:0]        strap;
    logic [cop_pkg::DATA_W-1:0]      rdata;
    cop_pkg::cop_se_s                se;
    cop_pkg::cop_diff_s              diff;
  } cop_main_s;

  cop_main_s                  s_reg;
  cop_main_s                  s_next;
  logic                       pci_tick;
  logic                       cpu_tick;
  logic                       cpu_rise;
  logic                       cpu_halt_q;
  logic                       pd_q;
  logic [cop_pkg::N_SE-1:0]   se_want;
  logic [cop_pkg::N_DIFF-1:0] diff_want;
  logic [cop_pkg::N_SE-1:0]   se_free;
  logic                       any_pair_halt;

  // ---------------------------------------------------------------------------
  // Phase dividers and input synchronisers
  // ---------------------------------------------------------------------------
  cop_tick_div #(.HALF(cop_pkg::PCI_HALF_CYC)) u_pci_div (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (pci_tick)
  );

  cop_tick_div #(.HALF(cop_pkg::CPU_HALF_CYC)) u_cpu_div (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (cpu_tick)
  );

  // The CPU halt is sampled only on rising CPU phase edges.
  assign cpu_rise = cpu_tick && !s_reg.cpu_ph;

  cop_sync2 #(.INIT(1'b1)) u_cpu_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .en       (cpu_rise), // R11
    .d        (cpu_clock_halt_n),
    .q        (cpu_halt_q)
  );

  // Power-down is asynchronous at the pin; low means power down.
  cop_sync2 #(.INIT(1'b0)) u_pd_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .en       (1'b1), // R12
    .d        (power_down_n_input),
    .q        (pd_q)
  );

  // ---------------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------------
  function automatic logic [cop_pkg::DATA_W-1:0] cop_read(
    input cop_pkg::cop_cfg_s          c,
    input logic [cop_pkg::ADDR_W-1:0] a,
    input logic [cop_pkg::DATA_W-1:0] stat
  );
    logic [cop_pkg::DATA_W-1:0] v;
    v = 8'h00;
    case (a)
      cop_pkg::REG_CTRL:    v = c.ctrl;
      cop_pkg::REG_SE_EN:   v = c.se_en;
      cop_pkg::REG_DIFF:    v = c.diff;
      cop_pkg::REG_SE_STOP: v = c.se_stop;
      cop_pkg::REG_FREE:    v = c.free;
      cop_pkg::REG_STATUS:  v = stat;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // Wanted run state of each output
  // ---------------------------------------------------------------------------
  // Only the last two single-ended outputs can be made free running.
  assign se_free       = {s_reg.cfg.free[1:0], 4'h0};
  assign any_pair_halt = !pci_clock_halt_n || !cpu_halt_q;

  always_comb begin
    for (int i = 0; i < cop_pkg::N_SE; i++) begin
      se_want[i] = s_reg.cfg.se_en[i] &&
                   !(s_reg.cfg.se_stop[i] && !pci_clock_halt_n && !se_free[i]); // R2 R3 R10
    end
    for (int j = 0; j < cop_pkg::N_DIFF; j++) begin
      diff_want[j] = !(s_reg.cfg.diff[cop_pkg::DIFF_STOP_LSB+j] && any_pair_halt); // R2 R3 R11
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic pci_fall;
    logic cpu_fall;
    logic low_pwr;
    logic pair_live;
    logic keep;
    logic mgmt;
    pci_fall  = 1'b0;
    cpu_fall  = 1'b0;
    low_pwr   = 1'b0;
    pair_live = 1'b0;
    keep      = s_reg.cfg.ctrl[cop_pkg::CTRL_KEEP_BIT];
    mgmt      = s_reg.cfg.ctrl[cop_pkg::CTRL_MGMT_BIT];
    s_next    = s_reg;
    s_next.rdata = 8'h00;

    pci_fall = pci_tick && s_reg.pci_ph;
    cpu_fall = cpu_tick && s_reg.cpu_ph;
    if (pci_tick) begin
      s_next.pci_ph = !s_reg.pci_ph;
    end
    if (cpu_tick) begin
      s_next.cpu_ph = !s_reg.cpu_ph;
    end

    // Register port; reads answer in the following cycle.
    if (bus_req.wr) begin
      case (bus_req.addr)
        cop_pkg::REG_CTRL:    s_next.cfg.ctrl    = bus_req.wdata;
        cop_pkg::REG_SE_EN:   s_next.cfg.se_en   = bus_req.wdata;
        cop_pkg::REG_DIFF:    s_next.cfg.diff    = bus_req.wdata;
        cop_pkg::REG_SE_STOP: s_next.cfg.se_stop = bus_req.wdata;
        cop_pkg::REG_FREE:    s_next.cfg.free    = bus_req.wdata;
        default:              ;
      endcase
    end
    if (bus_req.rd) begin
      s_next.rdata = cop_read(s_reg.cfg, bus_req.addr,
                              {2'b00, !cpu_halt_q, !pci_clock_halt_n, s_reg.st});
    end

    // Single-ended gates move only as the phase falls, so a high pulse is never cut.
    if (pci_fall) begin
      s_next.se_run = se_want; // R13 R1
    end
    // Pairs park or resume on a rising edge, when true is going high anyway.
    if (cpu_rise) begin
      s_next.diff_run = diff_want; // R13 R11
    end
    // Pair enables change while true is low.
    if (cpu_fall) begin
      s_next.diff_on = s_reg.cfg.diff[cop_pkg::DIFF_EN_LSB +: cop_pkg::N_DIFF]; // R13
    end

    // Power states change at a falling phase edge to keep outputs glitch free.
    unique case (s_reg.st)
      cop_pkg::ST_LATCH: begin
        s_next.strap = se_strap;
        if (pd_q && pci_fall) begin
          s_next.st = cop_pkg::ST_RUN;
        end
      end
      cop_pkg::ST_RUN: begin
        if (!pd_q && pci_fall) begin
          if (mgmt || keep) begin
            s_next.st = cop_pkg::ST_PDOWN; // R7 R8
          end else begin
            s_next.st  = cop_pkg::ST_LATCH; // R6
            s_next.cfg = cop_pkg::CFG_DEFAULT;
          end
        end else if (partial_power_state && pci_fall) begin
          s_next.st = cop_pkg::ST_PART;
        end
      end
      cop_pkg::ST_PDOWN: begin
        if (pd_q && pci_fall) begin
          s_next.st = cop_pkg::ST_RUN;
        end
      end
      cop_pkg::ST_PART: begin
        if (!partial_power_state && pci_fall) begin
          s_next.st = cop_pkg::ST_RUN;
        end
      end
      default: s_next.st = cop_pkg::ST_LATCH;
    endcase

    // Output drive from the next state so outputs come straight from flip-flops.
    low_pwr = s_next.st != cop_pkg::ST_RUN;
    for (int i = 0; i < cop_pkg::N_SE; i++) begin
      s_next.se.clk[i]  = !low_pwr && s_next.pci_ph && s_next.se_run[i]; // R2 R4 R5
      s_next.se.oe_n[i] = low_pwr && s_next.strap[i]; // R5
    end
    for (int j = 0; j < cop_pkg::N_DIFF; j++) begin
      pair_live = !low_pwr || (s_next.st == cop_pkg::ST_PART && j == cop_pkg::SECOND_CPU_PAIR_IDX); // R5
      if (pair_live && s_next.diff_on[j]) begin
        s_next.diff.t[j]      = s_next.diff_run[j] ? s_next.cpu_ph : 1'b1; // R2
        s_next.diff.c[j]      = s_next.diff_run[j] && !s_next.cpu_ph;
        s_next.diff.t_oe_n[j] = 1'b0;
      end else begin
        s_next.diff.t[j]      = 1'b0; // R4 R5
        s_next.diff.c[j]      = 1'b0;
        s_next.diff.t_oe_n[j] = s_next.cfg.diff[cop_pkg::DIFF_PD_LSB+j];
      end
    end
  end

  // State register; outputs idle low (or high-Z by strap) in the latched-open state from reset.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg     <= '0;
      s_reg.st  <= cop_pkg::ST_LATCH;
      s_reg.cfg <= cop_pkg::CFG_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata = s_reg.rdata;
  assign se_out    = s_reg.se;
  assign diff_out  = s_reg.diff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  localparam int RESUME_MAX = cop_pkg::PCI_RESUME_CYC;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  logic st_run;
  assign st_run = s_reg.st == cop_pkg::ST_RUN;

  property p_pci_resume;
    $rose(pci_clock_halt_n) && st_run && s_reg.cfg.se_en[0] |->
      ##[1:RESUME_MAX] (se_out.clk[0] || !st_run || !s_reg.cfg.se_en[0]);
  endproperty
  a_pci_resume: assert property (p_pci_resume) else $error("PCI output did not resume"); // R1

  property p_pci_park;
    (!pci_clock_halt_n && st_run && s_reg.cfg.se_stop[0] &&
     s_reg.cfg.diff[cop_pkg::DIFF_STOP_LSB] && s_reg.cfg.diff[cop_pkg::DIFF_EN_LSB])[*8] |->
      !se_out.clk[0] && diff_out.t[0] && !diff_out.c[0];
  endproperty
  a_pci_park: assert property (p_pci_park) else $error("PCI halt did not park outputs"); // R2

  property p_nonstop_runs;
    (st_run && s_reg.cfg.se_en[0] && !s_reg.cfg.se_stop[0])[*8] |->
      se_out.clk[0] != $past(se_out.clk[0], 2);
  endproperty
  a_nonstop_runs: assert property (p_nonstop_runs) else $error("Non-stoppable stalled"); // R3

  property p_disabled_low;
    (st_run && !s_reg.cfg.se_en[0] && !s_reg.cfg.diff[cop_pkg::DIFF_EN_LSB])[*8] |->
      !se_out.clk[0] && !diff_out.t[0] && !diff_out.c[0];
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("Disabled output not low"); // R4

  property p_low_power_drive;
    !st_run |-> !se_out.clk[0] && (se_out.oe_n[0] == s_reg.strap[0]) &&
      !diff_out.c[0] && !diff_out.t[0];
  endproperty
  a_low_power_drive: assert property (p_low_power_drive) else $error("Bad low power drive"); // R5

  property p_full_reset;
    st_run && !pd_q && !s_reg.cfg.ctrl[cop_pkg::CTRL_KEEP_BIT] &&
    !s_reg.cfg.ctrl[cop_pkg::CTRL_MGMT_BIT] |->
      ##[1:RESUME_MAX] (s_reg.st == cop_pkg::ST_LATCH && s_reg.cfg == cop_pkg::CFG_DEFAULT);
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("No full reset on power-down"); // R6

  property p_keep_cfg;
    st_run && !pd_q && s_reg.cfg.ctrl[cop_pkg::CTRL_KEEP_BIT] |->
      ##[1:RESUME_MAX] (s_reg.st == cop_pkg::ST_PDOWN && s_reg.cfg.ctrl[cop_pkg::CTRL_KEEP_BIT]);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("Configuration lost on power-down"); // R7

  property p_mgmt_no_reset;
    st_run && !pd_q && s_reg.cfg.ctrl[cop_pkg::CTRL_MGMT_BIT] |->
      ##[1:RESUME_MAX] (s_reg.st == cop_pkg::ST_PDOWN && s_reg.cfg.ctrl[cop_pkg::CTRL_MGMT_BIT]);
  endproperty
  a_mgmt_no_reset: assert property (p_mgmt_no_reset) else $error("Management mode reset"); // R8

  property p_free_running;
    (!pci_clock_halt_n && st_run && s_reg.cfg.se_en[cop_pkg::FREE_FIRST_SE] &&
     s_reg.cfg.free[0])[*8] |->
      se_out.clk[cop_pkg::FREE_FIRST_SE] != $past(se_out.clk[cop_pkg::FREE_FIRST_SE], 2);
  endproperty
  a_free_running: assert property (p_free_running) else $error("Free output stopped"); // R10

  property p_cpu_park;
    (!cpu_clock_halt_n && st_run && s_reg.cfg.diff[cop_pkg::DIFF_STOP_LSB] &&
     s_reg.cfg.diff[cop_pkg::DIFF_EN_LSB])[*8] |-> diff_out.t[0] && !diff_out.c[0];
  endproperty
  a_cpu_park: assert property (p_cpu_park) else $error("CPU halt did not park pair"); // R11

  property p_pd_synced;
    st_run && $fell(power_down_n_input) |=> st_run;
  endproperty
  a_pd_synced: assert property (p_pd_synced) else $error("Power-down acted unsynchronised"); // R12

  property p_no_runt;
    $rose(se_out.clk[0]) |=> se_out.clk[0];
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("Runt pulse on output"); // R13

  c_pci_stop_resume: cover property ($fell(pci_clock_halt_n) ##[1:20] $rose(se_out.clk[0]));
  c_enter_pdown:     cover property (st_run ##1 s_reg.st == cop_pkg::ST_PDOWN);
  c_full_reset:      cover property (st_run ##1 s_reg.st == cop_pkg::ST_LATCH);
  c_partial:         cover property (s_reg.st == cop_pkg::ST_PART && diff_out.t[1]);

endmodule

// *** tb/cop_chipset_model.sv ***
// Chipset model that drives the halt, power-down and partial-power pins of the controller.
`timescale 1ns/1ps
module cop_chipset_model (
  // Clock
  input  wire logic core_clk,
  // Requests from the test sequence
  input  wire logic pci_halt_req,
  input  wire logic cpu_halt_req,
  input  wire logic pd_req,
  input  wire logic part_req,
  // Pins toward the controller
  output logic      pci_clock_halt_n,
  output logic      cpu_clock_halt_n,
  output logic      power_down_n_input,
  output logic      partial_power_state
);
  // Pins start inactive, so the controller powers up with good power and no halts.
  initial begin
    pci_clock_halt_n    = 1'b1;
    cpu_clock_halt_n    = 1'b1;
    power_down_n_input  = 1'b1;
    partial_power_state = 1'b0;
  end

  // Pins move only just after a rising edge, the way a synchronous chipset drives them.
  always @(posedge core_clk) begin
    pci_clock_halt_n    <= ~pci_halt_req;
    cpu_clock_halt_n    <= ~cpu_halt_req;
    power_down_n_input  <= ~pd_req;
    partial_power_state <= part_req;
  end
endmodule

// *** tb/cop_ctrl_tb_top.sv ***
// Self-checking testbench for the clock output stop and power-down control.
`timescale 1ns/1ps
module cop_ctrl_tb_top;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                 core_clk = 1'b0;
  logic                 reset_n  = 1'b0;
  cop_pkg::cop_regbus_s bus_req  = '0;
  logic [7:0]           bus_rdata;
  logic                 pci_n, cpu_n, pd_n, part;
  logic                 pci_q = 1'b0, cpu_q = 1'b0, pd_q = 1'b0, part_q = 1'b0;
  cop_pkg::cop_se_s     se_out;
  cop_pkg::cop_diff_s   diff_out;
  logic [7:0]           se_or, se_and, t_or, t_and, c_or;
  logic                 split;
  int                   miscompares = 0;
  int                   cmp_count   = 0;

  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------------------
  cop_chipset_model u_cop_chipset_model (.core_clk(core_clk), .pci_halt_req(pci_q),
    .cpu_halt_req(cpu_q), .pd_req(pd_q), .part_req(part_q), .pci_clock_halt_n(pci_n),
    .cpu_clock_halt_n(cpu_n), .power_down_n_input(pd_n), .partial_power_state(part));
  cop_ctrl u_cop_ctrl (.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pci_clock_halt_n(pci_n), .cpu_clock_halt_n(cpu_n),
    .power_down_n_input(pd_n), .partial_power_state(part), .se_strap(6'h05),
    .se_out(se_out), .diff_out(diff_out));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one value, zero-extended to a byte, so unknown bits never match.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [cop_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rchk(input logic [cop_pkg::ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk($sformatf("reg%0d", a), exp, bus_rdata);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Watches the outputs on falling edges; OR shows any high, AND shows always high.
  task automatic watch(input int n);
    se_or  = 8'h00;
    se_and = 8'hff;
    t_or   = 8'h00;
    t_and  = 8'hff;
    c_or   = 8'h00;
    split  = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      se_or  = se_or | 8'(se_out.clk);
      se_and = se_and & 8'(se_out.clk);
      t_or   = t_or | 8'(diff_out.t);
      t_and  = t_and & 8'(diff_out.t);
      c_or   = c_or | 8'(diff_out.c);
      if (se_out.clk[3:0] != 4'h0 && se_out.clk[3:0] != 4'hf) split = 1'b1;
    end
  endtask

  // Drops power-down, checks the state, then restores power.
  task automatic pd_cycle(input logic [7:0] st, input logic [7:0] toe);
    pd_q <= 1'b1;
    idle(12);
    rchk(cop_pkg::REG_STATUS, st);
    watch(6);
    chk("se_low", 8'h00, se_or);
    chk("oe_n", 8'h05, 8'(se_out.oe_n));
    chk("pair", 8'h00, t_or | c_or);
    chk("t_oe_n", toe, 8'(diff_out.t_oe_n));
    pd_q <= 1'b0;
    idle(12);
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    idle(4);
    reset_n <= 1'b1;
    idle(10);
    rchk(cop_pkg::REG_STATUS, 8'h02);
    rchk(cop_pkg::REG_SE_EN, 8'h3f);
    rchk(cop_pkg::REG_DIFF, 8'h0f);
    wr(3'h7, 8'hff);
    rchk(3'h7, 8'h00);
    wr(cop_pkg::REG_FREE, 8'h01);
    pci_q <= 1'b1;
    idle(10);
    watch(8);
    chk("pci_stop", 8'h00, se_or & 8'h2f);
    chk("free_run", 8'h10, se_or & ~se_and & 8'h10);
    chk("park_t", 8'h03, t_and);
    chk("park_c", 8'h00, c_or);
    rchk(cop_pkg::REG_STATUS, 8'h12);
    pci_q <= 1'b0;
    watch(10);
    chk("resume", 8'h0f, se_or & 8'h0f);
    chk("split", 8'h00, 8'(split));
    cpu_q <= 1'b1;
    idle(12);
    watch(6);
    chk("se_runs", 8'h01, se_or & ~se_and & 8'h01);
    chk("cpu_park", 8'h03, t_and);
    chk("cpu_park_c", 8'h00, c_or);
    rchk(cop_pkg::REG_STATUS, 8'h22);
    wr(cop_pkg::REG_DIFF, 8'h03);
    idle(4);
    watch(6);
    chk("nonstop", 8'h03, t_or & ~t_and & 8'h03);
    cpu_q <= 1'b0;
    wr(cop_pkg::REG_SE_EN, 8'h3e);
    wr(cop_pkg::REG_DIFF, 8'h1e);
    idle(4);
    watch(6);
    chk("se_off", 8'h00, se_or & 8'h01);
    chk("pair_off", 8'h00, (t_or | c_or) & 8'h01);
    chk("pair_rel", 8'h01, 8'(diff_out.t_oe_n));
    wr(cop_pkg::REG_SE_EN, 8'h3f);
    wr(cop_pkg::REG_DIFF, 8'h3f);
    wr(cop_pkg::REG_CTRL, 8'h01);
    wr(cop_pkg::REG_SE_STOP, 8'h2a);
    pd_cycle(8'h04, 8'h03);
    rchk(cop_pkg::REG_SE_STOP, 8'h2a);
    wr(cop_pkg::REG_CTRL, 8'h08);
    pd_cycle(8'h04, 8'h03);
    rchk(cop_pkg::REG_SE_STOP, 8'h2a);
    wr(cop_pkg::REG_CTRL, 8'h00);
    pd_cycle(8'h01, 8'h00);
    rchk(cop_pkg::REG_SE_STOP, 8'h3f);
    rchk(cop_pkg::REG_STATUS, 8'h02);
    part_q <= 1'b1;
    idle(12);
    rchk(cop_pkg::REG_STATUS, 8'h08);
    watch(8);
    chk("m1_pair1", 8'h02, t_or & ~t_and & 8'h03);
    chk("m1_se", 8'h00, se_or);
    part_q <= 1'b0;
    idle(12);
    rchk(cop_pkg::REG_STATUS, 8'h02);
    stop_test();
  end

  // Watchdog sized well beyond the few hundred cycles the sequence needs.
  initial begin
    #(40 * 4000);
    miscompares++;
    stop_test();
  end
endmodule
